// [rtl/acp_control_port.sv]
// Converter control and output port top: calibration, power-down, memory clear
// What this block does
// - Output enable low drives, high floats outputs
// - Power-down request high enters power-down state
// - Coding select high gives two's complement
// - Memory clear pulse zeroes internal memory
// - Two-cycle calibration pulse enters calibration mode
// - Calibration-active output shows calibration mode
// - Fourteen-bit word, first bit is MSB
// - Rising edge clears, falling edge starts calibration
// - Calibration lasts 32775 cycles, busy held high
// - Data zero and inputs off while calibrating
// - Power-on settling delay then automatic calibration
`timescale 1ns/10ps
`include "acp_defines.svh"
module acp_control_port import acp_pkg::*; #(
	parameter int SAMPLE_W = `ACP_SAMPLE_W,
	parameter int SETTLE_CYC = `ACP_SETTLE_CYC,
	parameter int CAL_LEN_CYC = `ACP_CAL_LEN_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic outputEnableN,
	input wire logic powerDownRequest,
	input wire logic twosComplementSelect,
	input wire logic memClear,
	input wire logic calRequest,
	input wire logic [SAMPLE_W-1:0] rawSample,
	input wire logic rawValid,
	input wire logic rawOverRange,
	output logic calBusy,
	output logic calRegsClear,
	output logic analogInputEnable,
	output logic powerDownActive,
	output logic [SAMPLE_W-1:0] sampleOut,
	output logic [SAMPLE_W-1:0] sampleOe,
	output logic overRangeFlag
);
	if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << `ACP_CNT_W)) begin
		$error("SETTLE_CYC out of range");
	end
	if (CAL_LEN_CYC < 1 || CAL_LEN_CYC >= (1 << `ACP_CNT_W)) begin
		$error("CAL_LEN_CYC out of range");
	end

	localparam logic [`ACP_CNT_W-1:0] SETTLE_LAST = `ACP_CNT_W'(SETTLE_CYC - 1);
	localparam logic [`ACP_CNT_W-1:0] CAL_LAST = `ACP_CNT_W'(CAL_LEN_CYC - 1);

	acp_state_type stateReg;
	acp_state_type stateNext;
	logic [`ACP_CNT_W-1:0] cntReg;
	logic [`ACP_CNT_W-1:0] cntNext;
	logic calReqReg;
	logic clearPulseReg;

	wire calRise = calRequest & ~calReqReg;
	wire calFall = ~calRequest & calReqReg;
	wire settleDone = cntReg == SETTLE_LAST;
	wire calDone = cntReg == CAL_LAST;

	acp_ctrl_if ctrlBus();

	always_comb begin
		stateNext = stateReg;
		cntNext = cntReg + `ACP_CNT_W'(1);
		case (stateReg)
			ACP_SETTLE: begin
				if (settleDone) begin
					stateNext = ACP_CAL_RUN;
					cntNext = '0;
				end
			end
			ACP_CAL_ARM: begin
				cntNext = '0;
				if (calFall) begin
					stateNext = ACP_CAL_RUN;
				end
			end
			ACP_CAL_RUN: begin
				if (calRise) begin
					stateNext = ACP_CAL_ARM;
					cntNext = '0;
				end else if (calDone) begin
					stateNext = ACP_NORMAL;
					cntNext = '0;
				end
			end
			ACP_NORMAL: begin
				cntNext = '0;
				if (calRise) begin
					stateNext = ACP_CAL_ARM;
				end else if (powerDownRequest) begin
					stateNext = ACP_POWER_DOWN;
				end
			end
			ACP_POWER_DOWN: begin
				cntNext = '0;
				if (calRise) begin
					stateNext = ACP_CAL_ARM;
				end else if (!powerDownRequest) begin
					stateNext = ACP_NORMAL;
				end
			end
			default: begin
				stateNext = ACP_SETTLE;
				cntNext = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stateReg <= ACP_SETTLE;
			cntReg <= '0;
			calReqReg <= 1'b0;
			clearPulseReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			calReqReg <= calRequest;
			clearPulseReg <= calRise;
		end
	end

	wire calMode = stateReg == ACP_CAL_ARM || stateReg == ACP_CAL_RUN;

	assign ctrlBus.calActive = calMode;
	assign ctrlBus.powerDown = stateReg == ACP_POWER_DOWN;
	assign ctrlBus.memClear = memClear;

	assign calBusy = calMode;
	assign calRegsClear = clearPulseReg;
	assign analogInputEnable = stateReg == ACP_NORMAL;
	assign powerDownActive = stateReg == ACP_POWER_DOWN;

	acp_output_format #(
		.SAMPLE_W(SAMPLE_W)
	) u_fmt (
		.clk(clk),
		.sys_rst(sys_rst),
		.ctrl(ctrlBus.fmt),
		.rawSample(rawSample),
		.rawValid(rawValid),
		.rawOverRange(rawOverRange),
		.twosComplementSelect(twosComplementSelect),
		.outputEnableN(outputEnableN),
		.sampleOut(sampleOut),
		.sampleOe(sampleOe),
		.overRangeFlag(overRangeFlag)
	);

	// Helper: cycles spent in the current calibration run
	logic [`ACP_CNT_W-1:0] runLenReg;

	always_ff @(posedge clk) begin
		if (sys_rst || stateReg != ACP_CAL_RUN) begin
			runLenReg <= '0;
		end else begin
			runLenReg <= runLenReg + `ACP_CNT_W'(1);
		end
	end

	AST_CAL_ENTER: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_NORMAL && calRise |=> calBusy) else $error("Calibration not entered");
	AST_CAL_START: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_ARM && calFall |=> stateReg == ACP_CAL_RUN && cntReg == '0)
		else $error("Calibration did not start at falling edge");
	AST_CLR_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
		calRise |=> calRegsClear ##1 !calRegsClear) else $error("Clear pulse wrong");
	AST_CAL_END: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && calDone && !calRise |=> !calBusy && stateReg == ACP_NORMAL)
		else $error("Calibration did not end");
	AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && !calDone |=> calBusy) else $error("Busy dropped early");
	AST_SETTLE_CAL: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_SETTLE && settleDone |=> stateReg == ACP_CAL_RUN && calBusy)
		else $error("No calibration after settling");
	AST_PD_ENTER: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_NORMAL && powerDownRequest && !calRise |=> powerDownActive)
		else $error("Power-down not entered");
	AST_INPUT_OFF: assert property (@(posedge clk) disable iff (sys_rst)
		calBusy |-> !analogInputEnable) else $error("Inputs enabled in calibration");

	AST_RUN_NO_EARLY: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && runLenReg != CAL_LAST && !calRise |=> stateReg == ACP_CAL_RUN)
		else $error("Calibration ended early");
	AST_RUN_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && runLenReg == CAL_LAST |=> stateReg != ACP_CAL_RUN)
		else $error("Calibration ran too long");
	AST_ARM_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_ARM && !calFall |=> stateReg == ACP_CAL_ARM && calBusy)
		else $error("Calibration started before falling edge");
	AST_SETTLE_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_SETTLE && !settleDone |=> stateReg == ACP_SETTLE && !calBusy)
		else $error("Settling ended early");
	AST_PD_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
		powerDownActive && !powerDownRequest && !calRise |=> stateReg == ACP_NORMAL)
		else $error("Power-down not left");
	AST_PD_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		powerDownActive |=> sampleOut == '0)
		else $error("Data not zero in power-down");
	AST_PD_IN_CAL: assert property (@(posedge clk) disable iff (sys_rst)
		calBusy && powerDownRequest |=> !powerDownActive)
		else $error("Power-down taken during calibration");
	AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && calRise |=> stateReg == ACP_CAL_ARM && calRegsClear)
		else $error("Calibration not restarted");
	AST_CLR_ONLY_RISE: assert property (@(posedge clk) disable iff (sys_rst)
		!calRise |=> !calRegsClear)
		else $error("Clear pulse without rising edge");

	COV_DEMAND_CAL: cover property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_NORMAL && calRise ##1 calRequest ##1 calFall);
	COV_CAL_DONE: cover property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN ##1 stateReg == ACP_NORMAL);
	COV_POWER_DOWN: cover property (@(posedge clk) disable iff (sys_rst)
		powerDownActive ##1 !powerDownActive);
	COV_OVR: cover property (@(posedge clk) disable iff (sys_rst) overRangeFlag);
	COV_RESTART: cover property (@(posedge clk) disable iff (sys_rst)
		stateReg == ACP_CAL_RUN && calRise);
endmodule

// [rtl/acp_ctrl_if.sv]
// Control signals between the controller and the output formatter
`timescale 1ns/10ps
interface acp_ctrl_if;
	logic calActive;
	logic powerDown;
	logic memClear;
	modport ctrl (output calActive, output powerDown, output memClear);
	modport fmt (input calActive, input powerDown, input memClear);
endinterface

// [rtl/acp_defines.svh]
// Constants for the converter control and output port
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
`define ACP_SAMPLE_W 14
`define ACP_CLK_PERIOD_NS 100
`define ACP_CAL_PULSE_CYC 2
`define ACP_CAL_LEN_CYC 32775
`define ACP_SETTLE_CYC 2097152
`define ACP_CNT_W 22
`define ACP_MSB_MASK 14'h2000
`define ACP_MEM_RESET_VAL 14'h0000
`endif

// [rtl/acp_output_format.sv]
// Output word formatter: coding, zero forcing, over-range and tri-state
`timescale 1ns/10ps
`include "acp_defines.svh"
module acp_output_format import acp_pkg::*; #(
	parameter int SAMPLE_W = `ACP_SAMPLE_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	acp_ctrl_if.fmt ctrl,
	input wire logic [SAMPLE_W-1:0] rawSample,
	input wire logic rawValid,
	input wire logic rawOverRange,
	input wire logic twosComplementSelect,
	input wire logic outputEnableN,
	output logic [SAMPLE_W-1:0] sampleOut,
	output logic [SAMPLE_W-1:0] sampleOe,
	output logic overRangeFlag
);
	if (SAMPLE_W != `ACP_SAMPLE_W) begin
		$error("SAMPLE_W must be 14");
	end

	logic [SAMPLE_W-1:0] dataReg;
	logic [SAMPLE_W-1:0] dataNext;
	logic ovrReg;
	logic ovrNext;
	wire [SAMPLE_W-1:0] msbMask = `ACP_MSB_MASK;
	// Two's complement flips the MSB of the offset binary code
	wire [SAMPLE_W-1:0] codedSample = twosComplementSelect ? (rawSample ^ msbMask) : rawSample;
	wire forceZero = ctrl.calActive | ctrl.memClear | ctrl.powerDown;

	always_comb begin
		dataNext = dataReg;
		ovrNext = ovrReg;
		if (forceZero) begin
			dataNext = `ACP_MEM_RESET_VAL;
			ovrNext = 1'b0;
		end else if (rawValid) begin
			dataNext = codedSample;
			ovrNext = rawOverRange;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dataReg <= `ACP_MEM_RESET_VAL;
			ovrReg <= 1'b0;
		end else begin
			dataReg <= dataNext;
			ovrReg <= ovrNext;
		end
	end

	// Bit 13 is the first pin, bit 0 the fourteenth
	assign sampleOut = dataReg;
	assign sampleOe = {SAMPLE_W{~outputEnableN}};
	assign overRangeFlag = ovrReg;

	AST_CAL_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		$past(ctrl.calActive) |-> sampleOut == '0) else $error("Data not zero in calibration");
	AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst)
		(outputEnableN ? (sampleOe == '0) : (&sampleOe))) else $error("Output enable mismatch");
	AST_CODING: assert property (@(posedge clk) disable iff (sys_rst)
		!forceZero && rawValid |=>
			sampleOut[SAMPLE_W-1] == ($past(rawSample[SAMPLE_W-1]) ^ $past(twosComplementSelect))
			&& sampleOut[SAMPLE_W-2:0] == $past(rawSample[SAMPLE_W-2:0]))
		else $error("Coding wrong");
	AST_MEMCLR: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl.memClear |=> sampleOut == '0 && !overRangeFlag) else $error("Memory clear failed");
	AST_OVR: assert property (@(posedge clk) disable iff (sys_rst)
		!forceZero && rawValid |=> overRangeFlag == $past(rawOverRange)) else $error("Over-range wrong");
endmodule

// [rtl/acp_pkg.sv]
// Types for the converter control and output port
package acp_pkg;
	typedef enum logic [2:0] {
		ACP_SETTLE = 3'h0,
		ACP_CAL_ARM = 3'h1,
		ACP_CAL_RUN = 3'h2,
		ACP_NORMAL = 3'h3,
		ACP_POWER_DOWN = 3'h4
	} acp_state_type;
endpackage

// [sim/acp_capture_model.sv]
// Capture-side model driving calibration, samples and memory clear
`timescale 1ns/10ps
module acp_capture_model (
	input wire logic clk,
	output logic calRequest,
	output logic memClear,
	output logic [13:0] rawSample,
	output logic rawValid,
	output logic rawOverRange
);
	initial begin
		calRequest = 1'b0;
		memClear = 1'b0;
		rawSample = 14'h0000;
		rawValid = 1'b0;
		rawOverRange = 1'b0;
	end
	// Two-cycle calibration pulse
	task automatic cal_pulse();
		@(posedge clk) #1 calRequest = 1'b1;
		repeat (2) @(posedge clk);
		#1 calRequest = 1'b0;
	endtask
	// One sample, then stale lines scrambled
	task automatic send(input logic [13:0] s, input logic over_range_flag);
		@(posedge clk) #1 rawSample = s;
		rawOverRange = over_range_flag;
		rawValid = 1'b1;
		@(posedge clk) #1 rawValid = 1'b0;
		rawSample = ~s;
		rawOverRange = ~over_range_flag;
	endtask
	// Deliberate memory clear pulse
	task automatic clr_pulse();
		@(posedge clk) #1 memClear = 1'b1;
		@(posedge clk) #1 memClear = 1'b0;
		@(posedge clk) #1;
	endtask
endmodule

// [sim/acp_control_port_test.sv]
// Testbench for the converter control and output port
`timescale 1ns/10ps
module acp_control_port_test;
	logic clk, sys_rst, outputEnableN, powerDownRequest, twosComplementSelect;
	logic calRequest, memClear, rawValid, rawOverRange;
	logic [13:0] rawSample;
	logic calBusy, calRegsClear, analogInputEnable, powerDownActive, overRangeFlag;
	logic [13:0] sampleOut, sampleOe;
	int failures = 0;
	int cmp_count = 0;
	acp_control_port #(.SETTLE_CYC(20), .CAL_LEN_CYC(10)) dut (.clk(clk), .sys_rst(sys_rst),
		.outputEnableN(outputEnableN), .powerDownRequest(powerDownRequest),
		.twosComplementSelect(twosComplementSelect), .memClear(memClear), .calRequest(calRequest),
		.rawSample(rawSample), .rawValid(rawValid), .rawOverRange(rawOverRange), .calBusy(calBusy),
		.calRegsClear(calRegsClear), .analogInputEnable(analogInputEnable),
		.powerDownActive(powerDownActive), .sampleOut(sampleOut), .sampleOe(sampleOe),
		.overRangeFlag(overRangeFlag));
	acp_capture_model part (.clk(clk), .calRequest(calRequest), .memClear(memClear),
		.rawSample(rawSample), .rawValid(rawValid), .rawOverRange(rawOverRange));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [13:0] seen, input logic [13:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_busy(input logic lvl, output int n);
		n = 0;
		while (calBusy !== lvl) begin
			@(posedge clk) #1 n++;
			if (n > 100) begin
				failures++;
				end_sim();
			end
		end
	endtask
	task automatic run_cal(output int len);
		len = 0;
		while (calBusy === 1'b1) begin
			check(sampleOut, 14'h0000);
			check(analogInputEnable, 1'b0);
			check(overRangeFlag, 1'b0);
			@(posedge clk) #1 len++;
			if (len > 100) begin
				failures++;
				end_sim();
			end
		end
	endtask
	task automatic t_power_on();
		int n, len;
		wait_busy(1'b1, n);
		check(14'(n), 14'h0014);
		run_cal(len);
		check(14'(len), 14'h000A);
		check(analogInputEnable, 1'b1);
		$display("test power_on done");
	endtask
	task automatic t_format();
		part.send(14'h2ABC, 1'b1);
		check(sampleOut, 14'h2ABC);
		check(overRangeFlag, 1'b1);
		check(sampleOe, 14'h3FFF);
		twosComplementSelect = 1'b1;
		part.send(14'h2ABC, 1'b0);
		check(sampleOut, 14'h0ABC);
		check(overRangeFlag, 1'b0);
		part.send(14'h1234, 1'b0);
		check(sampleOut, 14'h3234);
		outputEnableN = 1'b1;
		@(posedge clk) #1 check(sampleOe, 14'h0000);
		outputEnableN = 1'b0;
		part.clr_pulse();
		check(sampleOut, 14'h0000);
		$display("test format done");
	endtask
	task automatic t_cal();
		int clr, len;
		clr = 0;
		part.send(14'h1111, 1'b1);
		check(sampleOut, 14'h3111);
		check(overRangeFlag, 1'b1);
		fork
			part.cal_pulse();
			repeat (4) begin
				@(posedge clk) #1;
				if (calRegsClear === 1'b1)
					clr++;
			end
		join
		check(14'(clr), 14'h0001);
		check(calBusy, 1'b1);
		fork
			run_cal(len);
			part.send(14'h0777, 1'b1);
		join
		check(14'(len), 14'h000A);
		part.send(14'h0101, 1'b0);
		check(sampleOut, 14'h2101);
		$display("test calibration done");
	endtask
	task automatic t_pdown();
		powerDownRequest = 1'b1;
		repeat (2) @(posedge clk);
		#1 check(powerDownActive, 1'b1);
		check(analogInputEnable, 1'b0);
		part.send(14'h0155, 1'b0);
		check(sampleOut, 14'h0000);
		powerDownRequest = 1'b0;
		repeat (2) @(posedge clk);
		#1 check(powerDownActive, 1'b0);
		part.send(14'h0155, 1'b0);
		check(sampleOut, 14'h2155);
		$display("test power_down done");
	endtask
	task automatic t_restart();
		int len;
		part.cal_pulse();
		repeat (3) @(posedge clk);
		part.cal_pulse();
		check(calBusy, 1'b1);
		@(posedge clk) #1 run_cal(len);
		check(14'(len), 14'h000A);
		check(analogInputEnable, 1'b1);
		$display("test restart done");
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		outputEnableN = 1'b0;
		powerDownRequest = 1'b0;
		twosComplementSelect = 1'b0;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_power_on();
		t_format();
		t_cal();
		t_pdown();
		t_restart();
		end_sim();
	end
endmodule
